// file: hw/dpg_pwm_ctrl.sv
// One modulation controller: a shared period counter and per-output compare.
// Assumes period and duty inputs are already clamped to legal ranges.
`timescale 1ns/1ps
`default_nettype none

module dpg_pwm_ctrl #(
    parameter int NOUT = 3,
    parameter int PW = 21
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable,
    input wire logic [PW-1:0] period_req,
    input wire logic [NOUT*dpg_pkg::DUTY_W-1:0] duty_req,
    output logic [NOUT-1:0] pwm_out,
    output logic running
);
    import dpg_pkg::*;

    localparam int PRODW = PW + DUTY_W + 11;

    logic [PW-1:0] count;
    logic [PW-1:0] period_act;
    logic [NOUT*PW-1:0] thr_req;
    logic [NOUT*PW-1:0] thr_act;
    logic boundary;

    // Reload only at the wrap or while stopped, so a new setting never cuts a period short
    assign boundary = !enable || (count == period_act - PW'(1)); // R13

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (boundary) begin
            count <= '0; // R13
        end else begin
            count <= count + PW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_act <= PW'(PERIOD_MIN_CYC);
            thr_act <= '0;
        end else if (boundary) begin
            period_act <= period_req; // R9 R13
            thr_act <= thr_req;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= 1'b0;
        end else begin
            running <= enable; // R5
        end
    end

    genvar g;
    generate
        for (g = 0; g < NOUT; g++) begin : g_out
            logic [PRODW-1:0] prod;
            // Scale by duty/1000 using a reciprocal multiply, error < 0.05%
            assign prod = PRODW'(period_req)
                * PRODW'(duty_req[g*DUTY_W +: DUTY_W])
                * PRODW'(DUTY_SCALE_MULT); // R7 R8
            assign thr_req[g*PW +: PW] = prod[DUTY_SCALE_SHIFT +: PW];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pwm_out[g] <= 1'b0;
                end else begin
                    pwm_out[g] <= enable
                        && (count < thr_act[g*PW +: PW]); // R7 R10
                end
            end
        end
    endgenerate

endmodule : dpg_pwm_ctrl

`default_nettype wire

// file: hw/dpg_top.sv
// Dual modulation controllers and a five-slot background pulse engine.
// Assumes an APB master on pclk; pin levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Pulses of 3 ms or more are timed by hardware without stalling anything.
// R2: Up to five background pulses run concurrently, each with pin and time.
// R3: A repeat request on a running pin reloads it; width zero ends it.
// R4: Controller one drives up to three outputs, controller two up to two.
// R5: Both controllers are enabled separately and run at their own frequency.
// R6: Each controller accepts frequencies from 20 Hz to 500 kHz.
// R7: Each output has its own duty, given as a percentage of high time.
// R8: Duty resolves to a tenth of a percent below 25 kHz.
// R9: New frequency and duty may be written while a controller runs.
// R10: Running outputs drive continuously; stopping releases pins to high-Z.
// R11: Starting a controller enables only the pins selected for its outputs.
// R12: A timed pulse takes the level opposite to the pin's level at request.
// R13: One period counter per controller; new values apply at period wrap.
module dpg_top #(
    parameter int PERIOD_MAX = dpg_pkg::PERIOD_MAX_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic ctrl_one_duty_first,
    output logic ctrl_one_duty_second,
    output logic ctrl_one_duty_third,
    output logic ctrl_two_duty_first,
    output logic ctrl_two_duty_second,
    output logic [4:0] pwm_oe,
    input wire logic [dpg_pkg::NUM_PINS-1:0] pin_level,
    output logic [dpg_pkg::NUM_PINS-1:0] pulse_pin_out,
    output logic [dpg_pkg::NUM_PINS-1:0] pulse_pin_oe
);
    import dpg_pkg::*;

    localparam int NDUTY = CTRL_ONE_OUTS + CTRL_TWO_OUTS;
    localparam int UW = 6;

    logic [6:0] ctrl;
    logic [PERIOD_W-1:0] period_one;
    logic [PERIOD_W-1:0] period_two;
    logic [NDUTY*DUTY_W-1:0] duty;
    logic [31:0] last_cmd;
    logic refused;
    logic [CTRL_ONE_OUTS-1:0] pwm_one;
    logic [CTRL_TWO_OUTS-1:0] pwm_two;
    logic run_one;
    logic run_two;

    // APB decode
    logic wr_en;
    logic rd_setup;
    logic addr_ok;
    logic [PERIOD_W-1:0] period_wr;
    logic [DUTY_W-1:0] duty_wr;
    logic [31:0] next_rdata;

    assign wr_en = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        if (paddr == ADDR_CTRL || paddr == ADDR_PERIOD_ONE
            || paddr == ADDR_PERIOD_TWO || paddr == ADDR_PULSE_CMD
            || paddr == ADDR_STATUS) begin
            addr_ok = 1'b1;
        end else if (paddr >= ADDR_DUTY_BASE
            && paddr < ADDR_DUTY_BASE + 8'(4 * NDUTY)
            && paddr[1:0] == 2'b00) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // Out-of-range frequencies are pinned to the nearest legal one
    always_comb begin
        if (pwdata[31:PERIOD_W] != '0 || pwdata[PERIOD_W-1:0]
            > PERIOD_W'(PERIOD_MAX)) begin
            period_wr = PERIOD_W'(PERIOD_MAX); // R6
        end else if (pwdata[PERIOD_W-1:0] < PERIOD_W'(PERIOD_MIN_CYC)) begin
            period_wr = PERIOD_W'(PERIOD_MIN_CYC); // R6
        end else begin
            period_wr = pwdata[PERIOD_W-1:0];
        end
        if (pwdata[31:DUTY_W] != '0 || pwdata[DUTY_W-1:0] > DUTY_FULL) begin
            duty_wr = DUTY_FULL; // R7
        end else begin
            duty_wr = pwdata[DUTY_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && paddr == ADDR_CTRL) begin
            ctrl <= pwdata[6:0]; // R5 R11
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_one <= PERIOD_RESET;
            period_two <= PERIOD_RESET;
        end else if (wr_en && paddr == ADDR_PERIOD_ONE) begin
            period_one <= period_wr; // R9
        end else if (wr_en && paddr == ADDR_PERIOD_TWO) begin
            period_two <= period_wr; // R9
        end
    end

    genvar d;
    generate
        for (d = 0; d < NDUTY; d++) begin : g_duty
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    duty[d*DUTY_W +: DUTY_W] <= DUTY_RESET;
                end else if (wr_en
                    && paddr == ADDR_DUTY_BASE + 8'(4 * d)) begin
                    duty[d*DUTY_W +: DUTY_W] <= duty_wr; // R7 R9
                end
            end
        end
    endgenerate

    // Modulation controllers
    dpg_pwm_ctrl #(
        .NOUT(CTRL_ONE_OUTS),
        .PW(PERIOD_W)
    ) u_ctrl_one (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl[CTRL_EN_ONE_BIT]),
        .period_req(period_one),
        .duty_req(duty[0 +: CTRL_ONE_OUTS*DUTY_W]),
        .pwm_out(pwm_one),
        .running(run_one)
    ); // R4 R5

    dpg_pwm_ctrl #(
        .NOUT(CTRL_TWO_OUTS),
        .PW(PERIOD_W)
    ) u_ctrl_two (
        .pclk(pclk),
        .presetn(presetn),
        .enable(ctrl[CTRL_EN_TWO_BIT]),
        .period_req(period_two),
        .duty_req(duty[CTRL_ONE_OUTS*DUTY_W +: CTRL_TWO_OUTS*DUTY_W]),
        .pwm_out(pwm_two),
        .running(run_two)
    ); // R4 R5

    assign ctrl_one_duty_first = pwm_one[0];
    assign ctrl_one_duty_second = pwm_one[1];
    assign ctrl_one_duty_third = pwm_one[2];
    assign ctrl_two_duty_first = pwm_two[0];
    assign ctrl_two_duty_second = pwm_two[1];

    // Unselected or stopped pins float so other logic may own them
    assign pwm_oe = {ctrl[CTRL_MASK_TWO_LSB +: CTRL_TWO_OUTS]
                        & {CTRL_TWO_OUTS{ctrl[CTRL_EN_TWO_BIT]}},
                     ctrl[CTRL_MASK_ONE_LSB +: CTRL_ONE_OUTS]
                        & {CTRL_ONE_OUTS{ctrl[CTRL_EN_ONE_BIT]}}}; // R10 R11

    // Pin level synchroniser; a change counts once stages two and three agree
    logic [NUM_PINS-1:0] lvl_s1;
    logic [NUM_PINS-1:0] lvl_s2;
    logic [NUM_PINS-1:0] lvl_s3;
    logic [NUM_PINS-1:0] lvl_stable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_s1 <= '0;
            lvl_s2 <= '0;
            lvl_s3 <= '0;
            lvl_stable <= '0;
        end else begin
            lvl_s1 <= pin_level;
            lvl_s2 <= lvl_s1;
            lvl_s3 <= lvl_s2;
            lvl_stable <= (lvl_s2 & lvl_s3) | (lvl_stable & (lvl_s2 | lvl_s3));
        end
    end

    // Microsecond tick for the pulse timers
    logic [UW-1:0] unit_cnt;
    logic unit_tick;

    assign unit_tick = (unit_cnt == UW'(PULSE_UNIT_CYC - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_cnt <= '0;
        end else if (unit_tick) begin
            unit_cnt <= '0;
        end else begin
            unit_cnt <= unit_cnt + UW'(1);
        end
    end

    // Pulse request decode and slot choice
    logic cmd_req;
    logic [PIN_W-1:0] cmd_pin;
    logic [WIDTH_W-1:0] cmd_width;
    dpg_slot_type slot [NUM_SLOTS];
    logic [NUM_SLOTS-1:0] hit;
    logic [NUM_SLOTS-1:0] alloc;
    logic any_hit;
    logic any_free;

    assign cmd_req = wr_en && paddr == ADDR_PULSE_CMD;
    assign cmd_pin = pwdata[CMD_PIN_LSB +: PIN_W];
    assign cmd_width = pwdata[CMD_WIDTH_LSB +: WIDTH_W];

    always_comb begin
        hit = '0;
        alloc = '0;
        any_hit = 1'b0;
        any_free = 1'b0;
        for (int i = 0; i < NUM_SLOTS; i++) begin
            if (slot[i].active && slot[i].pin == cmd_pin && !any_hit) begin
                hit[i] = 1'b1; // R3
                any_hit = 1'b1;
            end
            if (!slot[i].active && !any_free) begin
                alloc[i] = 1'b1; // R2
                any_free = 1'b1;
            end
        end
        if (any_hit) begin
            alloc = '0;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NUM_SLOTS; s++) begin : g_slot
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    slot[s] <= '0;
                end else if (cmd_req && hit[s]) begin
                    if (cmd_width == '0) begin
                        slot[s].active <= 1'b0; // R3
                    end else begin
                        slot[s].remain <= cmd_width; // R3
                    end
                end else if (cmd_req && alloc[s] && cmd_width != '0) begin
                    slot[s].active <= 1'b1; // R1 R2
                    slot[s].pin <= cmd_pin;
                    slot[s].level <= !lvl_stable[cmd_pin]; // R12
                    slot[s].remain <= cmd_width;
                end else if (slot[s].active && unit_tick) begin
                    if (slot[s].remain == WIDTH_W'(1)) begin
                        slot[s].active <= 1'b0; // R1
                    end
                    slot[s].remain <= slot[s].remain - WIDTH_W'(1);
                end
            end
        end
    endgenerate

    // No free slot and no match for a nonzero width: request dropped, flag it; set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused <= 1'b0;
        end else if (cmd_req && !any_hit && !any_free && cmd_width != '0) begin
            refused <= 1'b1;
        end else if (wr_en && paddr == ADDR_STATUS
            && pwdata[STAT_REFUSED_BIT]) begin
            refused <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_cmd <= '0;
        end else if (cmd_req) begin
            last_cmd <= pwdata;
        end
    end

    // Merge slots onto the pin bank
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pulse_pin_out <= '0;
            pulse_pin_oe <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                pulse_pin_out[p] <= 1'b0;
                pulse_pin_oe[p] <= 1'b0;
                for (int i = 0; i < NUM_SLOTS; i++) begin
                    if (slot[i].active && slot[i].pin == PIN_W'(p)) begin
                        pulse_pin_out[p] <= slot[i].level; // R12
                        pulse_pin_oe[p] <= 1'b1;
                    end
                end
            end
        end
    end

    // Read mux, captured in the setup cycle so prdata comes from a flop
    logic [NUM_SLOTS-1:0] busy;

    always_comb begin
        for (int i = 0; i < NUM_SLOTS; i++) begin
            busy[i] = slot[i].active;
        end
        next_rdata = '0;
        if (paddr == ADDR_CTRL) begin
            next_rdata[6:0] = ctrl;
        end else if (paddr == ADDR_PERIOD_ONE) begin
            next_rdata[PERIOD_W-1:0] = period_one;
        end else if (paddr == ADDR_PERIOD_TWO) begin
            next_rdata[PERIOD_W-1:0] = period_two;
        end else if (paddr == ADDR_PULSE_CMD) begin
            next_rdata = last_cmd;
        end else if (paddr == ADDR_STATUS) begin
            next_rdata[STAT_BUSY_LSB +: NUM_SLOTS] = busy;
            next_rdata[STAT_REFUSED_BIT] = refused;
            next_rdata[STAT_RUN_LSB +: 2] = {run_two, run_one};
        end else begin
            for (int i = 0; i < NDUTY; i++) begin
                if (paddr == ADDR_DUTY_BASE + 8'(4 * i)) begin
                    next_rdata[DUTY_W-1:0] = duty[i*DUTY_W +: DUTY_W];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

endmodule : dpg_top

`default_nettype wire

// file: pkg/dpg_pkg.sv
// Shared constants and types for the dual modulation and pulse generator.
// Assumes a single 40 MHz clock domain and an APB register interface.
package dpg_pkg;

    // Clock and timing
    localparam int CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_NS = 25;
    localparam int FREQ_MIN_HZ = 20;
    localparam int FREQ_MAX_HZ = 500_000;
    localparam int PERIOD_MIN_CYC = CLK_HZ / FREQ_MAX_HZ;
    localparam int PERIOD_MAX_CYC = CLK_HZ / FREQ_MIN_HZ;
    localparam int PERIOD_W = 21;
    localparam int PULSE_UNIT_NS = 1000;
    localparam int PULSE_UNIT_CYC = PULSE_UNIT_NS / CLK_PERIOD_NS;
    localparam int BG_PULSE_MIN_MS = 3;

    // Duty is held in tenths of a percent
    localparam int DUTY_W = 10;
    localparam logic [9:0] DUTY_FULL = 10'h3e8;
    localparam int DUTY_SCALE_MULT = 1049;
    localparam int DUTY_SCALE_SHIFT = 20;

    // Outputs per controller and pulse engine size
    localparam int CTRL_ONE_OUTS = 3;
    localparam int CTRL_TWO_OUTS = 2;
    localparam int NUM_SLOTS = 5;
    localparam int NUM_PINS = 8;
    localparam int PIN_W = 3;
    localparam int WIDTH_W = 24;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PERIOD_ONE = 8'h04;
    localparam logic [7:0] ADDR_PERIOD_TWO = 8'h08;
    localparam logic [7:0] ADDR_DUTY_BASE = 8'h0c;
    localparam logic [7:0] ADDR_PULSE_CMD = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    // Field positions
    localparam int CTRL_EN_ONE_BIT = 0;
    localparam int CTRL_EN_TWO_BIT = 1;
    localparam int CTRL_MASK_ONE_LSB = 2;
    localparam int CTRL_MASK_TWO_LSB = 5;
    localparam int CMD_PIN_LSB = 0;
    localparam int CMD_WIDTH_LSB = 8;
    localparam int STAT_BUSY_LSB = 0;
    localparam int STAT_REFUSED_BIT = 5;
    localparam int STAT_RUN_LSB = 6;

    // Reset values
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [20:0] PERIOD_RESET = 21'h009c40;
    localparam logic [9:0] DUTY_RESET = 10'h1f4;

    typedef struct packed {
        logic active;
        logic level;
        logic [PIN_W-1:0] pin;
        logic [WIDTH_W-1:0] remain;
    } dpg_slot_type;

endpackage : dpg_pkg

// file: testbench/dpg_top_chk.sv
// Port-level assertions for the dual modulation and pulse generator.
// Assumes it is bound into dpg_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module dpg_top_chk
    import dpg_pkg::*;
#(
    parameter int PERIOD_MAX = PERIOD_MAX_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ctrl_one_duty_first,
    input wire logic ctrl_one_duty_second,
    input wire logic ctrl_one_duty_third,
    input wire logic ctrl_two_duty_first,
    input wire logic ctrl_two_duty_second,
    input wire logic [4:0] pwm_oe,
    input wire logic [NUM_PINS-1:0] pin_level,
    input wire logic [NUM_PINS-1:0] pulse_pin_out,
    input wire logic [NUM_PINS-1:0] pulse_pin_oe
);
    logic ctrl_wr;
    logic cmd_wr;
    logic [1:0] en_q;
    logic [4:0] oe_q;
    logic [PIN_W-1:0] pin_q;
    logic [NUM_PINS-1:0] lvl_q;
    logic [3:0] calm;
    logic lvl_cmd;
    logic calm_cmd;
    assign ctrl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
    assign cmd_wr = psel && penable && pwrite && paddr == ADDR_PULSE_CMD;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 2'h0;
            oe_q <= 5'h00;
        end else if (ctrl_wr) begin
            en_q <= pwdata[1:0];
            oe_q <= {pwdata[6:5] & {2{pwdata[1]}}, pwdata[4:2] & {3{pwdata[0]}}};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 3'h0;
            lvl_cmd <= 1'b0;
            calm_cmd <= 1'b0;
        end else if (cmd_wr) begin
            pin_q <= pwdata[PIN_W-1:0];
            lvl_cmd <= pin_level[pwdata[PIN_W-1:0]];
            calm_cmd <= calm == 4'hf;
        end
    end
    // A level only counts once it has sat still well past the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lvl_q <= 8'h00;
            calm <= 4'h0;
        end else begin
            lvl_q <= pin_level;
            if (pin_level != lvl_q)
                calm <= 4'h0;
            else if (calm != 4'hf)
                calm <= calm + 4'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_err;
        pslverr == (psel && penable
            && (paddr > ADDR_STATUS || paddr[1:0] != 2'b00));
    endproperty
    property p_rd_hold;
        psel && penable && !pwrite |=> $stable(prdata);
    endproperty
    property p_oe_map;
        ctrl_wr |=> pwm_oe == oe_q;
    endproperty
    property p_oe_hold;
        !ctrl_wr |=> $stable(pwm_oe);
    endproperty
    property p_off_one;
        !en_q[0] [*3] |-> !(ctrl_one_duty_first || ctrl_one_duty_second ||
                            ctrl_one_duty_third);
    endproperty
    property p_off_two;
        !en_q[1] [*3] |-> !(ctrl_two_duty_first || ctrl_two_duty_second);
    endproperty
    property p_pulse_go;
        cmd_wr && pwdata[31:8] != 24'h0 && $countones(pulse_pin_oe) < 5
            |-> ##[1:3] pulse_pin_oe[pin_q];
    endproperty
    property p_pulse_end;
        cmd_wr && pwdata[31:8] == 24'h0 |-> ##[1:3] !pulse_pin_oe[pin_q];
    endproperty
    property p_pulse_lvl;
        calm_cmd && $rose(pulse_pin_oe[pin_q])
            |-> pulse_pin_out[pin_q] != lvl_cmd;
    endproperty
    a_err: assert property (p_err)
        else $error("slave error does not match the address");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved after the access");
    a_oe_map: assert property (p_oe_map)
        else $error("output enables differ from enable and mask");
    a_oe_hold: assert property (p_oe_hold)
        else $error("output enables changed without a control write");
    a_off_one: assert property (p_off_one)
        else $error("controller one output high while stopped");
    a_off_two: assert property (p_off_two)
        else $error("controller two output high while stopped");
    a_pulse_go: assert property (p_pulse_go)
        else $error("timed pulse did not start");
    a_pulse_end: assert property (p_pulse_end)
        else $error("zero width did not end the pulse");
    a_pulse_lvl: assert property (p_pulse_lvl)
        else $error("pulse level equals the resting level");
    c_pwm_on: cover property (ctrl_wr && pwdata[0]);
    c_pulse: cover property ($rose(pulse_pin_oe[2]));
    c_err: cover property (pslverr);
endmodule : dpg_top_chk

bind dpg_top dpg_top_chk #(.PERIOD_MAX(PERIOD_MAX)) dpg_top_chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .ctrl_one_duty_first(ctrl_one_duty_first),
    .ctrl_one_duty_second(ctrl_one_duty_second),
    .ctrl_one_duty_third(ctrl_one_duty_third),
    .ctrl_two_duty_first(ctrl_two_duty_first),
    .ctrl_two_duty_second(ctrl_two_duty_second), .pwm_oe(pwm_oe),
    .pin_level(pin_level), .pulse_pin_out(pulse_pin_out),
    .pulse_pin_oe(pulse_pin_oe));

`default_nettype wire

// file: testbench/test_dpg_top.sv
// Self-checking bench: APB register traffic, output counting, pulse timing.
// Assumes the checker file is compiled too; it binds itself to dpg_top.
`timescale 1ns/1ps
`default_nettype none

module test_dpg_top;
    import dpg_pkg::*;
    // Short longest period keeps the run small yet shows 0.1 percent steps
    localparam int PMAX = 2000;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] pv;
    logic [4:0] pwm_oe;
    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pulse_pin_out;
    logic [NUM_PINS-1:0] pulse_pin_oe;
    logic [31:0] rdv;
    logic errv;
    int fail_count;
    int comparisons;
    int cnt [5];
    int n;
    int per [5] = '{100, 100, 100, 80, 80};
    int dut [5] = '{0, 500, 1000, 250, 750};

    dpg_top #(.PERIOD_MAX(PMAX)) dpg_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ctrl_one_duty_first(pv[0]),
        .ctrl_one_duty_second(pv[1]), .ctrl_one_duty_third(pv[2]),
        .ctrl_two_duty_first(pv[3]), .ctrl_two_duty_second(pv[4]),
        .pwm_oe(pwm_oe), .pin_level(pin_level),
        .pulse_pin_out(pulse_pin_out), .pulse_pin_oe(pulse_pin_oe));

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && w < 50) begin
            @(posedge pclk);
            w++;
        end
        if (w >= 50)
            fail_count++;
        rdv = prdata;
        errv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Callers look at outputs only once the access edge has settled
        @(negedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rdv, e);
    endtask : rd

    task automatic measure(input int cycles);
        cnt = '{default: 0};
        repeat (cycles) begin
            @(negedge pclk);
            for (int i = 0; i < 5; i++)
                if (pv[i] === 1'b1)
                    cnt[i]++;
        end
    endtask : measure

    task automatic pulse_len(input int pin, output int len);
        len = 0;
        while (pulse_pin_oe[pin] === 1'b1 && len < 10000) begin
            @(negedge pclk);
            len++;
        end
    endtask : pulse_len

    function automatic int thr(input int p, input int d);
        // Duty is in tenths of a percent of the period
        return p * d / 1000;
    endfunction : thr

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    initial begin
        repeat (60000) @(posedge pclk);
        fail_count++;
        close_out();
    end

    initial begin
        fail_count = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pin_level = 8'h0f;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, 8'h40, 32'hffff_ffff);
        check(errv, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, errv}, 32'h1);
        check(rdv, 32'h0);
        rd(ADDR_CTRL, 32'h0);
        rd(ADDR_PERIOD_ONE, 32'h9c40);
        rd(ADDR_DUTY_BASE + 8'h10, 32'h1f4);
        rd(ADDR_STATUS, 32'h0);
        wr(ADDR_PERIOD_TWO, 32'd5000);
        rd(ADDR_PERIOD_TWO, 32'd2000);
        wr(ADDR_DUTY_BASE + 8'h10, 32'd1500);
        rd(ADDR_DUTY_BASE + 8'h10, 32'h3e8);
        // Period two is below the floor and runs at 80 cycles
        wr(ADDR_PERIOD_ONE, 32'd100);
        wr(ADDR_PERIOD_TWO, 32'd10);
        for (int i = 0; i < 5; i++)
            wr(ADDR_DUTY_BASE + 8'(4 * i), 32'(dut[i]));
        wr(ADDR_CTRL, 32'h7f);
        check(pwm_oe, 5'h1f);
        rd(ADDR_STATUS, 32'hc0);
        repeat (400) @(posedge pclk);
        measure(400);
        for (int i = 0; i < 5; i++)
            check(cnt[i], (400 / per[i]) * thr(per[i], dut[i]));
        wr(ADDR_CTRL, 32'h15);
        check(pwm_oe, 5'h05);
        measure(400);
        check(cnt[3] + cnt[4], 32'h0);
        check(cnt[2], 32'd400);
        wr(ADDR_PERIOD_ONE, 32'd2000);
        wr(ADDR_DUTY_BASE, 32'd500);
        repeat (2100) @(posedge pclk);
        measure(2000);
        check(cnt[0], thr(2000, 500));
        wr(ADDR_DUTY_BASE, 32'd501);
        repeat (2100) @(posedge pclk);
        measure(2000);
        check(cnt[0], thr(2000, 501));
        wr(ADDR_CTRL, 32'h0);
        check(pwm_oe, 5'h00);
        wr(ADDR_PULSE_CMD, {24'd5, 8'h02});
        wr(ADDR_PULSE_CMD, {24'd3, 8'h05});
        repeat (3) @(negedge pclk);
        check({pulse_pin_oe[5], pulse_pin_oe[2]}, 2'b11);
        check({pulse_pin_out[5], pulse_pin_out[2]}, 2'b10);
        pulse_len(2, n);
        check(32'(n >= 150 && n <= 240), 32'h1);
        for (int i = 0; i < 5; i++)
            wr(ADDR_PULSE_CMD, {24'd50, 8'(i)});
        wr(ADDR_PULSE_CMD, {24'd50, 8'h07});
        check(pulse_pin_oe, 8'h1f);
        rd(ADDR_STATUS, 32'h3f);
        wr(ADDR_STATUS, 32'h20);
        rd(ADDR_STATUS, 32'h1f);
        wr(ADDR_PULSE_CMD, {24'd0, 8'h01});
        repeat (3) @(negedge pclk);
        check(pulse_pin_oe[1], 1'b0);
        wr(ADDR_PULSE_CMD, {24'd200, 8'h00});
        repeat (2400) @(negedge pclk);
        check(pulse_pin_oe, 8'h01);
        pulse_len(0, n);
        check(32'(n >= 5500 && n <= 5700), 32'h1);
        rd(ADDR_STATUS, 32'h0);
        close_out();
    end
endmodule : test_dpg_top

`default_nettype wire
